// [rwd_pin_stretch.sv]
// Purpose: Holds the open-drain reset pin low for a fixed count
// Assumes: Start is a one-cycle pulse
// Notes:   A start during an active stretch restarts the count
`timescale 1ns/1ns
module rwd_pin_stretch
   import rwd_pkg::*;
#(
   parameter int unsigned LOW_CYCLES = RWD_PIN_LOW_CYCLES
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Control
   input  wire logic start,
   // Pin drive
   output logic      pin_out,
   output logic      pin_oe
);

   logic [5:0] count;
   logic [5:0] next_count;
   logic       next_oe;

   // ----------------------------------------------------------------
   // Stretch counter
   // ----------------------------------------------------------------
   // Pin is driven low only while the count runs
   always_comb begin
      next_count = count;
      next_oe    = pin_oe;
      if (start) begin
         next_count = 6'h00;
         next_oe    = 1'b1;
      end else if (pin_oe) begin
         if (count == 6'(LOW_CYCLES - 1)) begin   // see [R5]
            next_oe    = 1'b0;
            next_count = 6'h00;
         end else begin
            next_count = count + 6'h01;
         end
      end
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count   <= 6'h00;
         pin_oe  <= 1'b0;
         pin_out <= 1'b0;
      end else begin
         count   <= next_count;
         pin_oe  <= next_oe;
         pin_out <= 1'b0;
      end
   end

   AST_PIN_LOW_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(pin_oe) |-> $past(count) == 6'(LOW_CYCLES - 1))   // see [R5]
      else $error("reset pin low phase has wrong length");

endmodule : rwd_pin_stretch

// [rwd_pkg.sv]
// Purpose: Shared constants for the runaway code watchdog
// Assumes: One 100 MHz clock standing in for the oscillator clock
// Notes:   Offsets are register indices; byte address is index times four
package rwd_pkg;

   // ----------------------------------------------------------------
   // Counter structure
   // ----------------------------------------------------------------
   localparam int unsigned RWD_PRESCALER_W = 12;
   localparam int unsigned RWD_WATCHDOG_W  = 6;
   // Lowest prescaler bit cleared by a service write (stage 5)
   localparam int unsigned RWD_CLEAR_LSB   = 4;
   localparam int unsigned RWD_LONG_DIV    = 4096;
   localparam int unsigned RWD_SHORT_DIV   = 128;
   localparam int unsigned RWD_LONG_TIMEOUT_CYCLES  = 262128;
   localparam int unsigned RWD_SHORT_TIMEOUT_CYCLES = 8176;
   localparam int unsigned RWD_POR_DELAY_CYCLES     = 4096;
   localparam int unsigned RWD_PIN_LOW_CYCLES       = 32;

   // ----------------------------------------------------------------
   // Register map (indices)
   // ----------------------------------------------------------------
   localparam int unsigned RWD_ADDR_W         = 18;
   localparam int unsigned RWD_CLEAR_INDEX    = 32'h0000FFFF;
   localparam int unsigned RWD_STATUS_INDEX   = 32'h00000000;
   localparam int unsigned RWD_STATE_INDEX    = 32'h00000001;
   localparam logic [17:0] RWD_CLEAR_ADDR     = 18'(RWD_CLEAR_INDEX * 4);
   localparam logic [17:0] RWD_STATUS_ADDR    = 18'(RWD_STATUS_INDEX * 4);
   localparam logic [17:0] RWD_STATE_ADDR     = 18'(RWD_STATE_INDEX * 4);
   // Watchdog flag position in the reset status register
   localparam int unsigned RWD_FLAG_BIT       = 1;
   localparam logic [31:0] RWD_STATUS_RESET   = 32'h00000000;

endpackage : rwd_pkg

// [rwd_watchdog.sv]
// Purpose: Runaway code watchdog with APB access and reset pin drive
// Assumes: pclk is the oscillator clock; presetn is the power-on reset
// Notes:   Configuration bits arrive live from write-once latches
//
// What this block does
// [R1] 6-bit counter fed by 12-bit prescaler carry
// [R2] Overflow gives reset after 262128 or 8176 cycles
// [R3] Clear write zeroes counter and prescaler stages 12-5
// [R4] Clear location reads reset vector low byte
// [R5] Timeout pulls reset pin low 32 cycles, flags
// [R6] Stop clears prescaler; stop mode halts counting
// [R7] Prescaler cleared 4096 cycles after power-up
// [R8] Internal reset clears prescaler and watchdog counter
// [R9] Disable bit suppresses counting and resets
// [R10] Monitor entry with test voltage disables meanwhile
// [R11] Blank-vector monitor entry disables until power-on
// [R12] Break with test voltage on reset disables
// [R13] Counting continues in wait mode
// [R14] No interrupt request, only reset
// [R15] Disallowed stop gives illegal opcode reset
// [R16] Software services after reset and around stop
// [R17] Software services from main loop only
// [R18] Rate select 1 short, 0 long, reset clears
// [R19] Disable bit 1 disables, 0 enables
// [R20] Configuration taken live, no private copy
//
// The APB register port was decided locally.
`timescale 1ns/1ns
module rwd_watchdog
   import rwd_pkg::*;
#(
   parameter int unsigned LONG_TIMEOUT  = RWD_LONG_TIMEOUT_CYCLES,
   parameter int unsigned SHORT_TIMEOUT = RWD_SHORT_TIMEOUT_CYCLES,
   parameter int unsigned LONG_DIV      = RWD_LONG_DIV,
   parameter int unsigned SHORT_DIV     = RWD_SHORT_DIV
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [17:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Configuration latches
   input  wire logic        watchdog_disable,
   input  wire logic        watchdog_rate_select,
   input  wire logic        stop_enable,
   // System status
   input  wire logic [7:0]  reset_vector_low,
   input  wire logic        internal_reset,
   input  wire logic        stop_exec,
   input  wire logic        stop_mode,
   input  wire logic        monitor_entry,
   input  wire logic        break_active,
   input  wire logic        test_voltage_irq,
   input  wire logic        test_voltage_rst,
   // Reset outputs
   output logic             system_reset,
   output logic             illegal_opcode_reset,
   output logic             reset_pin_out,
   output logic             reset_pin_oe
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Cycles elapsed since the counters were zero, for a tap divider
   function automatic int unsigned elapsed(input logic [5:0] wd, input logic [11:0] pre,
                                           input int unsigned div);
      elapsed = int'(wd) * div + (int'(pre) % div);
   endfunction : elapsed

   // Carry out of the selected prescaler tap
   function automatic logic tap_carry(input logic [11:0] pre, input int unsigned div);
      tap_carry = ((int'(pre) % div) == div - 1);
   endfunction : tap_carry

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [11:0] prescaler_counter;
   logic [5:0]  watchdog_count;
   logic        por_done;
   logic        mon_vtst;
   logic        mon_blank;
   logic        watchdog_flag;
   logic [11:0] next_prescaler_counter;
   logic [5:0]  next_watchdog_count;
   logic        next_por_done;
   logic        next_mon_vtst;
   logic        next_mon_blank;
   logic        next_watchdog_flag;
   logic        next_system_reset;
   logic        next_illegal;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;

   logic        apb_done;
   logic        clear_write;
   logic        status_write;
   logic        enabled;
   logic        hold_clear;
   logic        overflow;
   logic        pin_busy;
   int unsigned div_sel;
   int unsigned timeout_sel;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Writes act only at the completing edge of the access phase
   assign apb_done     = psel & penable & pready;
   assign clear_write  = apb_done & pwrite & (paddr == RWD_CLEAR_ADDR);   // see [R3]
   assign status_write = apb_done & pwrite & (paddr == RWD_STATUS_ADDR);

   // Rate and disable are read straight from the latches
   assign div_sel     = watchdog_rate_select ? SHORT_DIV : LONG_DIV;           // see [R18] [R20]
   assign timeout_sel = watchdog_rate_select ? SHORT_TIMEOUT : LONG_TIMEOUT;   // see [R2]
   assign enabled     = ~watchdog_disable & ~mon_vtst & ~mon_blank              // see [R9] [R19]
                        & ~(break_active & test_voltage_rst);                  // see [R12]

   // Any reset source, including our own pin phase, empties both counters
   assign hold_clear  = internal_reset | illegal_opcode_reset | system_reset | pin_busy;   // see [R8]

   // ----------------------------------------------------------------
   // Counter chain
   // ----------------------------------------------------------------
   // Wait mode has no input here: counting simply carries on through it
   always_comb begin
      next_prescaler_counter = prescaler_counter;
      next_watchdog_count    = watchdog_count;
      next_por_done          = por_done;
      overflow               = 1'b0;
      if (hold_clear) begin
         next_prescaler_counter = 12'h000;   // see [R8]
         next_watchdog_count    = 6'h00;
      end else if (stop_exec && stop_enable) begin
         // Stop instruction clears the prescaler even as stop mode begins
         next_prescaler_counter = 12'h000;   // see [R6]
      end else if (stop_mode) begin
         // Oscillator removed from the chain, nothing moves
         next_prescaler_counter = prescaler_counter;   // see [R6]
      end else if (!por_done) begin
         if (prescaler_counter == 12'(RWD_POR_DELAY_CYCLES - 1)) begin
            next_prescaler_counter = 12'h000;   // see [R7]
            next_por_done          = 1'b1;
         end else begin
            next_prescaler_counter = prescaler_counter + 12'h001;
         end
      end else if (clear_write) begin
         // Stages below the cleared range keep running, so periods jitter by up to 15
         next_prescaler_counter = {prescaler_counter[11:RWD_CLEAR_LSB] & 8'h00,
                                   prescaler_counter[RWD_CLEAR_LSB-1:0] + 4'h1};   // see [R3]
         next_watchdog_count    = 6'h00;
      end else begin
         next_prescaler_counter = prescaler_counter + 12'h001;   // see [R13]
         if (!enabled) begin
            next_watchdog_count = 6'h00;   // see [R9]
         end else begin
            if (tap_carry(prescaler_counter, div_sel)) begin
               next_watchdog_count = watchdog_count + 6'h01;   // see [R1]
            end
            if (elapsed(watchdog_count, prescaler_counter, div_sel) == timeout_sel - 1) begin
               overflow = 1'b1;   // see [R2]
            end
         end
      end
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler_counter <= 12'h000;
         watchdog_count    <= 6'h00;
         por_done          <= 1'b0;
      end else begin
         prescaler_counter <= next_prescaler_counter;
         watchdog_count    <= next_watchdog_count;
         por_done          <= next_por_done;
      end
   end

   // ----------------------------------------------------------------
   // Monitor mode, flags and reset pulses
   // ----------------------------------------------------------------
   // Blank-vector hold survives every reset except power-on
   always_comb begin
      next_mon_vtst  = mon_vtst;
      next_mon_blank = mon_blank;
      if (monitor_entry && test_voltage_irq) begin
         next_mon_vtst = 1'b1;   // see [R10]
      end else if (monitor_entry) begin
         next_mon_blank = 1'b1;   // see [R11]
      end else if (!test_voltage_irq && !test_voltage_rst) begin
         next_mon_vtst = 1'b0;   // see [R10]
      end
      // Set wins over a software clear in the same cycle
      next_watchdog_flag = watchdog_flag;
      if (status_write && pwdata[RWD_FLAG_BIT]) begin
         next_watchdog_flag = 1'b0;
      end
      if (overflow) begin
         next_watchdog_flag = 1'b1;   // see [R5]
      end
      next_system_reset = overflow;   // see [R14]
      next_illegal      = stop_exec & ~stop_enable & ~hold_clear;   // see [R15]
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_vtst             <= 1'b0;
         mon_blank            <= 1'b0;
         watchdog_flag        <= 1'b0;
         system_reset         <= 1'b0;
         illegal_opcode_reset <= 1'b0;
      end else begin
         mon_vtst             <= next_mon_vtst;
         mon_blank            <= next_mon_blank;
         watchdog_flag        <= next_watchdog_flag;
         system_reset         <= next_system_reset;
         illegal_opcode_reset <= next_illegal;
      end
   end

   // Reset pin stretcher
   rwd_pin_stretch #(
      .LOW_CYCLES (RWD_PIN_LOW_CYCLES)
   ) u_pin (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (overflow),
      .pin_out (reset_pin_out),
      .pin_oe  (reset_pin_oe)
   );
   assign pin_busy = reset_pin_oe;

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // One wait state: data is registered on the same edge that pready rises
   always_comb begin
      next_pready  = psel & penable & ~pready;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      if (psel && penable && !pready) begin
         next_prdata = 32'h00000000;
         if (paddr == RWD_CLEAR_ADDR) begin
            next_prdata = {24'h000000, reset_vector_low};   // see [R4]
         end else if (paddr == RWD_STATUS_ADDR) begin
            next_prdata[RWD_FLAG_BIT] = watchdog_flag;
         end else if (paddr == RWD_STATE_ADDR) begin
            next_prdata = {4'h0, prescaler_counter, 2'h0, watchdog_count,
                           4'h0, enabled, mon_blank, mon_vtst, por_done};
         end else begin
            next_pslverr = 1'b1;
         end
      end
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= RWD_STATUS_RESET;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_OVERFLOW_FLAG_PIN: assert property (@(posedge pclk) disable iff (!presetn)   // see [R5]
      system_reset |-> watchdog_flag && reset_pin_oe && !reset_pin_out)
      else $error("overflow did not flag and pull the pin");
   AST_SERVICE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)   // see [R3]
      clear_write && por_done && !hold_clear && !stop_mode && !stop_exec |=>
         watchdog_count == 6'h00 && prescaler_counter[11:RWD_CLEAR_LSB] == 8'h00)
      else $error("service write did not clear the counters");
   AST_READ_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)   // see [R4]
      psel && penable && !pready && !pwrite && paddr == RWD_CLEAR_ADDR |=>
         pready && prdata == {24'h000000, $past(reset_vector_low)})
      else $error("clear location did not read the vector byte");
   AST_DISABLED_NO_RESET: assert property (@(posedge pclk) disable iff (!presetn)   // see [R9]
      watchdog_disable |=> !system_reset)
      else $error("reset raised while disabled");
   AST_BLANK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)   // see [R11]
      mon_blank |=> mon_blank && !enabled)
      else $error("blank-vector hold released before power-on");
   AST_STOP_HALTS: assert property (@(posedge pclk) disable iff (!presetn)   // see [R6]
      stop_mode && !stop_exec && !hold_clear |=> $stable(prescaler_counter) && $stable(watchdog_count))
      else $error("counters moved in stop mode");
   AST_ILLEGAL_STOP: assert property (@(posedge pclk) disable iff (!presetn)   // see [R15]
      stop_exec && !stop_enable && !hold_clear |=> illegal_opcode_reset ##1
         prescaler_counter == 12'h000 && watchdog_count == 6'h00)
      else $error("disallowed stop did not reset");
   AST_POR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)   // see [R7]
      !por_done && prescaler_counter == 12'(RWD_POR_DELAY_CYCLES - 1) && !hold_clear && !stop_mode && !stop_exec
         |=> por_done && prescaler_counter == 12'h000)
      else $error("power-up clear missed");
   AST_INTERNAL_RESET: assert property (@(posedge pclk) disable iff (!presetn)   // see [R8]
      internal_reset |=> prescaler_counter == 12'h000 && watchdog_count == 6'h00)
      else $error("internal reset left counts");
   AST_BREAK_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)   // see [R12]
      break_active && test_voltage_rst |=> !system_reset ##0 watchdog_count == 6'h00)
      else $error("watchdog ran during break with test voltage");
   AST_MONITOR_VTST: assert property (@(posedge pclk) disable iff (!presetn)   // see [R10]
      monitor_entry && test_voltage_irq ##1 (test_voltage_irq || test_voltage_rst)[*2]
         |-> !enabled)
      else $error("monitor hold dropped with test voltage present");

   COV_TIMEOUT:  cover property (@(posedge pclk) disable iff (!presetn) $rose(system_reset));
   COV_SERVICE:  cover property (@(posedge pclk) disable iff (!presetn) clear_write && watchdog_count != 6'h00);
   COV_ILLEGAL:  cover property (@(posedge pclk) disable iff (!presetn) $rose(illegal_opcode_reset));
   COV_PIN_DONE: cover property (@(posedge pclk) disable iff (!presetn) $fell(reset_pin_oe));

endmodule : rwd_watchdog

// [rwd_watchdog_tb_top.sv]
// Purpose: Self-checking bench for the runaway code watchdog
// Assumes: Timeouts shortened through the timeout and divider parameters
// Notes:   A service write keeps the low prescaler bits, so windows allow one divider step
`timescale 1ns/1ns
module rwd_watchdog_tb_top;
   import rwd_pkg::*;

   // ------------------------------------------------------------
   // Shortened timing, keeping 63*DIV <= T < 64*DIV
   // ------------------------------------------------------------
   localparam int T_L   = 1008;
   localparam int DIV_L = 16;
   localparam int T_S   = 504;
   localparam int DIV_S = 8;

   logic        pclk;
   logic        presetn;
   logic [17:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        watchdog_disable;
   logic        watchdog_rate_select;
   logic        stop_enable;
   logic [7:0]  reset_vector_low;
   logic        internal_reset;
   logic        stop_exec;
   logic        stop_mode;
   logic        monitor_entry;
   logic        break_active;
   logic        test_voltage_irq;
   logic        test_voltage_rst;
   logic        system_reset;
   logic        illegal_opcode_reset;
   logic        reset_pin_out;
   logic        reset_pin_oe;
   int          failures;
   int          checks_done;
   logic [31:0] rd;
   logic        er;

   rwd_watchdog #(.LONG_TIMEOUT(T_L), .SHORT_TIMEOUT(T_S), .LONG_DIV(DIV_L), .SHORT_DIV(DIV_S)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .watchdog_disable(watchdog_disable), .watchdog_rate_select(watchdog_rate_select),
      .stop_enable(stop_enable), .reset_vector_low(reset_vector_low), .internal_reset(internal_reset),
      .stop_exec(stop_exec), .stop_mode(stop_mode), .monitor_entry(monitor_entry),
      .break_active(break_active), .test_voltage_irq(test_voltage_irq), .test_voltage_rst(test_voltage_rst),
      .system_reset(system_reset), .illegal_opcode_reset(illegal_opcode_reset),
      .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe));

   // ------------------------------------------------------------
   // Clock, 10 ns period
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks made %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   // One APB transfer; idle edge first so back-to-back calls never reassign psel
   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         chk(32'h0, 32'h1, "no ready");
         wrap_up();
      end
   endtask : apb

   task automatic rd_chk(input logic [17:0] a, input logic [31:0] mask, input logic [31:0] exp, input string m);
      apb(1'b0, a, 32'h00000000);
      chk(rd & mask, exp, m);
   endtask : rd_chk

   task automatic service(input logic [31:0] d);
      apb(1'b1, RWD_CLEAR_ADDR, d);
      chk(32'(er), 32'h0, "service refused");
   endtask : service

   // Waits for the overflow reset, then times the pin phase
   task automatic wait_rst(input int lo, input int hi, input string m);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (system_reset !== 1'b1 && n < hi + 50);
      chk(32'(n >= lo && n <= hi), 32'h1, m);
      if (n >= hi + 50) wrap_up();
      n = 0;
      while (reset_pin_oe === 1'b1 && n < 64) begin
         chk(32'(reset_pin_out), 32'h0, "pin level");
         @(posedge pclk);
         if (n == 0) chk(32'(system_reset), 32'h0, "reset pulse width");
         n++;
      end
      chk(n, 32, "pin low length");
   endtask : wait_rst

   task automatic quiet(input int cyc, input string m);
      int k;
      k = 0;
      repeat (cyc) begin
         @(posedge pclk);
         if (system_reset === 1'b1) k++;
      end
      chk(k, 0, m);
   endtask : quiet

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      failures = 0;
      checks_done = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {watchdog_disable, internal_reset, stop_exec, stop_mode} = '0;
      {monitor_entry, break_active, test_voltage_irq, test_voltage_rst} = '0;
      watchdog_rate_select = 1'b1;
      stop_enable = 1'b1;
      reset_vector_low = 8'hA5;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Map, refusal and power-up phase
      rd_chk(RWD_STATE_ADDR, 32'h00000001, 32'h00000000, "power-up phase");
      rd_chk(RWD_CLEAR_ADDR, 32'hFFFFFFFF, 32'h000000A5, "clear location read");
      apb(1'b0, 18'h00100, 32'h00000000);
      chk(rd, 32'h00000000, "unmapped read data");
      chk(32'(er), 32'h00000001, "unmapped access refused");
      rd_chk(RWD_STATUS_ADDR, 32'hFFFFFFFF, 32'h00000000, "status reset value");
      repeat (RWD_POR_DELAY_CYCLES + 8) @(posedge pclk);
      rd_chk(RWD_STATE_ADDR, 32'h00000009, 32'h00000009, "counting enabled");
      $display("test map done");
      // Short timeout, flag, clear
      service(32'h00000000);
      wait_rst(T_S - DIV_S - 2, T_S + 2, "short timeout");
      rd_chk(RWD_STATUS_ADDR, 32'h00000002, 32'h00000002, "flag set");
      apb(1'b1, RWD_STATUS_ADDR, 32'h00000002);
      rd_chk(RWD_STATUS_ADDR, 32'h00000002, 32'h00000000, "flag cleared");
      // Long rate chosen live, then an exact restart after the pin phase
      watchdog_rate_select <= 1'b0;
      service(32'hFFFFFFFF);
      wait_rst(T_L - DIV_L - 2, T_L + 2, "long timeout");
      wait_rst(T_L - 2, T_L + 2, "restart after pin phase");
      $display("test timeout done");
      // Regular servicing keeps the reset away
      for (int i = 0; i < 4; i++) begin
         quiet(T_L / 2, "serviced");
         service(32'h5A5A5A5A);
      end
      $display("test service done");
      // Disable bit used live
      watchdog_disable <= 1'b1;
      quiet(T_L + 100, "disabled");
      rd_chk(RWD_STATE_ADDR, 32'h00000008, 32'h00000000, "enabled bit low");
      watchdog_disable <= 1'b0;
      service(32'h00000001);
      wait_rst(T_L - DIV_L - 2, T_L + 2, "enabled again");
      $display("test disable done");
      // Stop mode halts counting; software services on leaving it
      stop_exec <= 1'b1;
      stop_mode <= 1'b1;
      @(posedge pclk);
      stop_exec <= 1'b0;
      rd_chk(RWD_STATE_ADDR, 32'h0FFF0000, 32'h00000000, "stop cleared prescaler");
      quiet(T_L + 100, "stop mode");
      stop_mode <= 1'b0;
      service(32'h00000002);
      wait_rst(T_L - DIV_L - 2, T_L + 2, "after stop");
      // Disallowed stop gives the illegal opcode reset
      stop_enable <= 1'b0;
      stop_exec <= 1'b1;
      @(posedge pclk);
      stop_exec <= 1'b0;
      @(posedge pclk);
      chk(32'(illegal_opcode_reset), 32'h1, "illegal stop");
      stop_enable <= 1'b1;
      wait_rst(T_L - DIV_L - 4, T_L + 4, "after illegal reset");
      // Internal reset clears both counters
      service(32'h00000003);
      quiet(300, "before internal reset");
      internal_reset <= 1'b1;
      @(posedge pclk);
      internal_reset <= 1'b0;
      wait_rst(T_L - 4, T_L + 4, "after internal reset");
      $display("test stop and internal reset done");
      // Monitor entry with test voltage, then held by the reset pin test voltage alone
      test_voltage_irq <= 1'b1;
      monitor_entry <= 1'b1;
      @(posedge pclk);
      monitor_entry <= 1'b0;
      test_voltage_irq <= 1'b0;
      test_voltage_rst <= 1'b1;
      quiet(T_L + 100, "monitor hold");
      test_voltage_rst <= 1'b0;
      service(32'h00000004);
      wait_rst(T_L - DIV_L - 2, T_L + 2, "monitor released");
      // Break with test voltage on the reset pin
      break_active <= 1'b1;
      test_voltage_rst <= 1'b1;
      quiet(T_L + 100, "break hold");
      break_active <= 1'b0;
      test_voltage_rst <= 1'b0;
      service(32'h00000005);
      wait_rst(T_L - DIV_L - 2, T_L + 2, "break released");
      // Blank-vector monitor entry lasts until power-on reset
      monitor_entry <= 1'b1;
      @(posedge pclk);
      monitor_entry <= 1'b0;
      quiet(T_L + 100, "blank hold");
      service(32'h00000006);
      quiet(T_L + 100, "blank hold after service");
      do_reset();
      repeat (RWD_POR_DELAY_CYCLES + 8) @(posedge pclk);
      service(32'h00000007);
      wait_rst(T_L - DIV_L - 2, T_L + 2, "after power-on reset");
      $display("test monitor and break done");
      wrap_up();
   end

endmodule : rwd_watchdog_tb_top
